// file: logic/sdram_power_refresh_control.sv
// Purpose: power management and refresh restart of an sdram controller
// Assumes: access requests, idle request and warm reset come from logic on i_clk
// Notes:   memory commands and cke are registered; grant is combinational
//
// Behaviour
// - after reset, auto-refresh stays stopped until a mode-register write.
// - a mode-register write returns the state machine to normal, refresh resumes.
// - every mode-register command is preceded by an atomic precharge, accesses held.
// - memories enter self-refresh when idle only through trigger select 0x2 or an enabled idle request.
// - trigger select 0x2 enters self-refresh when the idle timeout expires.
// - idle timeout count sets the timeout in units; 0x1 is one unit.
// - trigger select 0 disables every idle-counter feature.
// - power-down enable 0 keeps cke high outside self-refresh.
// - power control 0xC1 means high bandwidth, no power-down, clock on, no idle count, self-refresh on idle request and on warm reset.
// - if enabled, a hardware idle request puts memory in self-refresh.
// - if enabled, a warm reset puts memory in self-refresh.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module sdram_power_refresh_control
   import sdram_power_refresh_pkg::*;
(
   input  wire logic                                  i_clk,
   input  wire logic                                  i_rst_n,
   input  wire logic [sdram_power_refresh_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [sdram_power_refresh_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                                  i_wr,
   input  wire logic                                  i_rd,
   output logic      [sdram_power_refresh_pkg::DATA_W-1:0] o_rdata,
   input  wire logic                                  i_access_req,
   output logic                                       o_access_grant,
   input  wire logic                                  i_idle_req,
   output logic                                       o_idle_ack,
   input  wire logic                                  i_warm_rst,
   output sdram_power_refresh_pkg::cmd_t               o_mem_cmd,
   output logic      [sdram_power_refresh_pkg::MODE_W-1:0] o_mem_mode,
   output logic                                       o_mem_cke,
   output logic                                       o_mem_clk_en
);

   import sdram_power_refresh_pkg::*;

   // ==========================================================
   // register port
   logic [DATA_W-1:0] power_q;
   logic [DATA_W-1:0] power_d;
   logic [DATA_W-1:0] mode_q;
   logic [DATA_W-1:0] mode_d;
   logic [CNT_W-1:0]  interval_q;
   logic [CNT_W-1:0]  interval_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic              mode_wr;

   state_t            state_q;
   state_t            state_d;
   logic [WAIT_W-1:0] wait_q;
   logic [WAIT_W-1:0] wait_d;
   cmd_t              cmd_q;
   cmd_t              cmd_d;
   logic              cke_q;
   logic              cke_d;
   logic              clk_en_q;
   logic              clk_en_d;
   logic              active_q;
   logic              active_d;
   logic              pending_q;
   logic              pending_d;
   logic              due_q;
   logic              due_d;
   logic              warm_q;
   logic              warm_d;

   // field views
   logic [1:0]        trigger;
   logic [CNT_W-1:0]  idle_count;
   logic              pwd_en;
   logic              sr_on_idle;
   logic              sr_on_warm;
   logic              ext_clk_dis;

   assign trigger     = power_q[TRIGGER_SELECT_LSB +: 2];
   assign idle_count  = power_q[IDLE_TIMEOUT_COUNT_LSB +: CNT_W];
   assign pwd_en      = power_q[POWER_DOWN_ENABLE_BIT];
   assign sr_on_idle  = power_q[SELF_REFRESH_ON_IDLE_REQ_BIT];
   assign sr_on_warm  = power_q[SELF_REFRESH_ON_WARM_RST_BIT];
   assign ext_clk_dis = power_q[EXT_CLOCK_DISABLE_BIT];

   assign mode_wr = i_wr && (i_addr == MEMORY_MODE_CONFIG_OFS);

   always_comb
   begin
      power_d    = power_q;
      mode_d     = mode_q;
      interval_d = interval_q;
      rdata_d    = '0;
      if (i_wr)
      begin
         unique case (i_addr)
            MEMORY_POWER_CONTROL_OFS: power_d    = i_wdata & POWER_CONTROL_MASK;
            MEMORY_MODE_CONFIG_OFS:   mode_d     = i_wdata;
            REFRESH_INTERVAL_OFS:     interval_d = i_wdata[CNT_W-1:0];
            default:                  power_d    = power_q;
         endcase
      end
      if (i_rd)
      begin
         unique case (i_addr)
            MEMORY_POWER_CONTROL_OFS: rdata_d = power_q;
            MEMORY_MODE_CONFIG_OFS:   rdata_d = mode_q;
            REFRESH_INTERVAL_OFS:     rdata_d = {{(DATA_W-CNT_W){1'b0}}, interval_q};
            CONTROLLER_STATUS_OFS:
               rdata_d = {{(DATA_W-9){1'b0}}, clk_en_q, cke_q, warm_q, due_q,
                          pending_q, active_q, state_q};
            default:                  rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         power_q    <= POWER_CONTROL_RST;
         mode_q     <= MODE_CONFIG_RST;
         interval_q <= REFRESH_INTERVAL_RST;
         rdata_q    <= '0;
      end
      else
      begin
         power_q    <= power_d;
         mode_q     <= mode_d;
         interval_q <= interval_d;
         rdata_q    <= rdata_d;
      end
   end

   assign o_rdata = rdata_q;

   // ==========================================================
   // idle and refresh timing
   logic unit_tick;
   logic idle_zero;
   logic idle_load;
   logic idle_expired;
   logic refresh_zero;
   logic refresh_tick;
   logic sr_req;
   logic power_wr;

   assign power_wr = i_wr && (i_addr == MEMORY_POWER_CONTROL_OFS);

   tick_divider #(
      .DIV     (IDLE_UNIT_CYCLES)
   ) u_unit (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .o_tick  (unit_tick)
   );

   // busy or disabled keeps the idle counter reloaded; a power write reloads so a stale zero never expires
   assign idle_load = i_access_req || (trigger == TRIGGER_NONE)
                      || power_wr || !(state_q == S_NORMAL || state_q == S_POWER_DOWN);

   interval_timer #(
      .W       (CNT_W)
   ) u_idle (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_load  (idle_load),
      .i_value (power_d[IDLE_TIMEOUT_COUNT_LSB +: CNT_W]),
      .i_en    (unit_tick),
      .o_zero  (idle_zero)
   );

   // a zero count means no timeout at all
   assign idle_expired = idle_zero && !idle_load && (idle_count != IDLE_COUNT_OFF);

   // refresh counter only runs once a mode write has restarted it
   interval_timer #(
      .W       (CNT_W)
   ) u_refresh (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_load  (!active_q || refresh_zero),
      .i_value (interval_q),
      .i_en    (1'b1),
      .o_zero  (refresh_zero)
   );

   assign refresh_tick = active_q && refresh_zero;

   assign sr_req = active_q
                   && ((trigger == TRIGGER_SELF_REFRESH && idle_expired)
                       || (sr_on_idle && i_idle_req)
                       || warm_q);

   // ==========================================================
   // power and refresh state machine
   always_comb
   begin
      state_d   = state_q;
      wait_d    = (wait_q != WAIT_NONE) ? wait_q - 1'b1 : WAIT_NONE;
      cmd_d     = CMD_NOP;
      cke_d     = cke_q;
      active_d  = active_q;
      pending_d = pending_q || mode_wr;
      due_d     = due_q || refresh_tick;
      warm_d    = warm_q || (i_warm_rst && sr_on_warm);
      clk_en_d  = clk_en_q;
      if (wait_q == WAIT_NONE)
      begin
         unique case (state_q)
            S_HALT:
               if (pending_q)
               begin
                  state_d = S_PRECHARGE;
                  cmd_d   = CMD_PRECHARGE_ALL;
                  wait_d  = T_RP_CYC;
               end
            S_PRECHARGE:
            begin
               state_d   = S_MODE_SET;
               cmd_d     = CMD_MODE_SET;
               wait_d    = T_MRD_CYC;
               pending_d = mode_wr;
            end
            S_MODE_SET:
            begin
               state_d  = S_NORMAL;
               active_d = 1'b1;
            end
            S_NORMAL:
               if (pending_q)
               begin
                  state_d = S_PRECHARGE;
                  cmd_d   = CMD_PRECHARGE_ALL;
                  wait_d  = T_RP_CYC;
               end
               else if (due_q)
               begin
                  state_d = S_REFRESH;
                  cmd_d   = CMD_AUTO_REFRESH;
                  wait_d  = T_RFC_CYC;
                  due_d   = refresh_tick;
               end
               else if (sr_req)
               begin
                  state_d = S_SELF_REFRESH;
                  cmd_d   = CMD_SELF_REFRESH;
                  cke_d   = 1'b0;
               end
               else if (pwd_en && !i_access_req)
               begin
                  state_d = S_POWER_DOWN;
                  cke_d   = 1'b0;
               end
            S_REFRESH:
               state_d = S_NORMAL;
            S_POWER_DOWN:
               if (i_access_req || due_q || pending_q || sr_req || !pwd_en)
               begin
                  state_d = S_NORMAL;
                  cke_d   = 1'b1;
                  wait_d  = T_XP_CYC;
               end
            S_SELF_REFRESH:
            begin
               // memory refreshes itself; the periodic request is dropped
               due_d = 1'b0;
               if (pending_q || (i_access_req && !(sr_on_idle && i_idle_req)))
               begin
                  state_d = S_SR_EXIT;
                  cke_d   = 1'b1;
                  wait_d  = T_XSR_CYC;
                  warm_d  = i_warm_rst && sr_on_warm;
               end
            end
            S_SR_EXIT:
               state_d = S_NORMAL;
         endcase
      end
      // clock to memory stops only where the memory tolerates it
      clk_en_d = !((ext_clk_dis && state_d == S_SELF_REFRESH)
                   || (trigger == TRIGGER_CLOCK_STOP && idle_expired
                       && state_d == S_POWER_DOWN));
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q   <= S_HALT;
         wait_q    <= WAIT_NONE;
         cmd_q     <= CMD_NOP;
         cke_q     <= 1'b1;
         clk_en_q  <= 1'b1;
         active_q  <= 1'b0;
         pending_q <= 1'b0;
         due_q     <= 1'b0;
         warm_q    <= 1'b0;
      end
      else
      begin
         state_q   <= state_d;
         wait_q    <= wait_d;
         cmd_q     <= cmd_d;
         cke_q     <= cke_d;
         clk_en_q  <= clk_en_d;
         active_q  <= active_d;
         pending_q <= pending_d;
         due_q     <= due_d;
         warm_q    <= warm_d;
      end
   end

   // ==========================================================
   // outputs
   // grant drops for the whole precharge and mode sequence, so it is atomic
   assign o_access_grant = (state_q == S_NORMAL) && (wait_q == WAIT_NONE)
                           && !pending_q && !due_q && !sr_req;
   assign o_idle_ack     = (state_q == S_SELF_REFRESH);
   assign o_mem_cmd      = cmd_q;
   assign o_mem_mode     = mode_q[MODE_W-1:0];
   assign o_mem_cke      = cke_q;
   assign o_mem_clk_en   = clk_en_q;

endmodule : sdram_power_refresh_control

// file: logic/sdram_power_refresh_pkg.sv
// Purpose: shared constants and types of the sdram power and refresh control
// Assumes: 125 MHz controller clock, 32-bit register port
// Notes:   register offsets are byte addresses
package sdram_power_refresh_pkg;

   // ==========================================================
   // bus and clock
   localparam int ADDR_W  = 32;
   localparam int DATA_W  = 32;
   localparam int CLK_MHZ = 125;
   localparam int MODE_W  = 14;
   localparam int CNT_W   = 16;
   localparam int WAIT_W  = 5;

   // ==========================================================
   // register offsets
   localparam logic [ADDR_W-1:0] MEMORY_POWER_CONTROL_OFS = 32'h6d000070;
   localparam logic [ADDR_W-1:0] MEMORY_MODE_CONFIG_OFS   = 32'h6d000084;
   localparam logic [ADDR_W-1:0] REFRESH_INTERVAL_OFS     = 32'h6d0000a4;
   localparam logic [ADDR_W-1:0] CONTROLLER_STATUS_OFS    = 32'h6d0000b0;

   // ==========================================================
   // memory_power_control fields
   localparam int HIGH_POWER_BANDWIDTH_MODE_BIT = 0;
   localparam int EXT_CLOCK_DISABLE_BIT         = 1;
   localparam int POWER_DOWN_ENABLE_BIT         = 2;
   localparam int TRIGGER_SELECT_LSB            = 4;
   localparam int SELF_REFRESH_ON_IDLE_REQ_BIT  = 6;
   localparam int SELF_REFRESH_ON_WARM_RST_BIT  = 7;
   localparam int IDLE_TIMEOUT_COUNT_LSB        = 8;
   localparam logic [DATA_W-1:0] POWER_CONTROL_MASK = 32'h00fffff7;

   localparam logic [1:0] TRIGGER_NONE         = 2'h0;
   localparam logic [1:0] TRIGGER_CLOCK_STOP   = 2'h1;
   localparam logic [1:0] TRIGGER_SELF_REFRESH = 2'h2;

   // ==========================================================
   // reset values
   localparam logic [DATA_W-1:0] POWER_CONTROL_RST    = 32'h000000c1;
   localparam logic [DATA_W-1:0] MODE_CONFIG_RST      = 32'h00000000;
   localparam logic [CNT_W-1:0]  REFRESH_INTERVAL_RST = 16'h03cf;
   localparam logic [CNT_W-1:0]  IDLE_COUNT_OFF       = 16'h0000;

   // ==========================================================
   // timing
   localparam int IDLE_UNIT_CYCLES = 64;
   localparam int T_RP_NS  = 18;
   localparam int T_RFC_NS = 72;
   localparam int T_XSR_NS = 120;
   localparam logic [WAIT_W-1:0] T_RP_CYC  = WAIT_W'((T_RP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [WAIT_W-1:0] T_RFC_CYC = WAIT_W'((T_RFC_NS * CLK_MHZ + 999) / 1000);
   localparam logic [WAIT_W-1:0] T_XSR_CYC = WAIT_W'((T_XSR_NS * CLK_MHZ + 999) / 1000);
   localparam logic [WAIT_W-1:0] T_MRD_CYC = 5'h02;
   localparam logic [WAIT_W-1:0] T_XP_CYC  = 5'h01;
   localparam logic [WAIT_W-1:0] WAIT_NONE = 5'h00;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      S_HALT         = 3'b000,
      S_PRECHARGE    = 3'b001,
      S_MODE_SET     = 3'b011,
      S_NORMAL       = 3'b010,
      S_REFRESH      = 3'b110,
      S_SELF_REFRESH = 3'b111,
      S_SR_EXIT      = 3'b101,
      S_POWER_DOWN   = 3'b100
   } state_t;

   typedef enum logic [2:0] {
      CMD_NOP           = 3'h0,
      CMD_PRECHARGE_ALL = 3'h1,
      CMD_AUTO_REFRESH  = 3'h2,
      CMD_MODE_SET      = 3'h3,
      CMD_SELF_REFRESH  = 3'h4
   } cmd_t;

endpackage : sdram_power_refresh_pkg

// file: logic/tick_divider.sv
// Purpose: one-cycle enable pulse every DIV clock cycles
// Assumes: DIV of two or more
// Notes:   free running from reset
`timescale 1ns/1ps
module tick_divider #(
   parameter int DIV = 64
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   output logic      o_tick
);

   // ==========================================================
   // divider
   localparam int W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   always_comb
   begin
      cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   assign o_tick = (cnt_q == LAST);

endmodule : tick_divider

// file: logic/interval_timer.sv
// Purpose: loadable down counter, steps on an enable, reports zero
// Assumes: load has priority over counting
// Notes:   holds at zero until loaded again
`timescale 1ns/1ps
module interval_timer #(
   parameter int W = 16
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_value,
   input  wire logic         i_en,
   output logic              o_zero
);

   // ==========================================================
   // counter
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   always_comb
   begin
      cnt_d = cnt_q;
      if (i_load)
         cnt_d = i_value;
      else if (i_en && cnt_q != '0)
         cnt_d = cnt_q - 1'b1;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   assign o_zero = (cnt_q == '0);

endmodule : interval_timer

// file: tb/sdram_power_refresh_control_assertions.sv
// Purpose: concurrent checks on the ports of sdram_power_refresh_control
// Assumes: register writes take effect one cycle after the strobe
// Notes:   shadows of power control and mode config follow the write port
`timescale 1ns/1ps
module sdram_power_refresh_control_assertions
   import sdram_power_refresh_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              o_access_grant,
   input  wire logic              o_idle_ack,
   input  cmd_t                   o_mem_cmd,
   input  wire logic [MODE_W-1:0] o_mem_mode,
   input  wire logic              o_mem_cke,
   input  wire logic              o_mem_clk_en
);
   // ======================================================
   // shadows
   logic              refresh_on_q;
   logic              refresh_on_d;
   logic [DATA_W-1:0] pwr_q;
   logic [DATA_W-1:0] pwr_d;
   logic [MODE_W-1:0] mode_q;
   logic [MODE_W-1:0] mode_d;
   always_comb
   begin
      refresh_on_d = refresh_on_q | (o_mem_cmd == CMD_MODE_SET);
      pwr_d        = pwr_q;
      mode_d       = mode_q;
      if (i_wr && i_addr == MEMORY_POWER_CONTROL_OFS)
         pwr_d = i_wdata;
      if (i_wr && i_addr == MEMORY_MODE_CONFIG_OFS)
         mode_d = i_wdata[MODE_W-1:0];
   end
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         refresh_on_q <= 1'b0;
         pwr_q        <= POWER_CONTROL_RST;
         mode_q       <= '0;
      end
      else
      begin
         refresh_on_q <= refresh_on_d;
         pwr_q        <= pwr_d;
         mode_q       <= mode_d;
      end
   end
   // ======================================================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_prech_before_mode: assert property (
      o_mem_cmd == CMD_MODE_SET |-> $past(o_mem_cmd, 4) == CMD_PRECHARGE_ALL)
      else $error("mode set not preceded by precharge four cycles earlier");
   a_atomic_no_grant: assert property (
      o_mem_cmd == CMD_PRECHARGE_ALL |-> !o_access_grant [*5])
      else $error("grant given between precharge and mode set");
   a_refresh_needs_mode: assert property (
      o_mem_cmd == CMD_AUTO_REFRESH |-> refresh_on_q)
      else $error("auto refresh before any mode set");
   a_mode_value_sent: assert property (
      o_mem_cmd == CMD_MODE_SET |-> o_mem_mode == mode_q)
      else $error("mode set carries a stale mode value");
   a_self_refresh_cke: assert property (
      o_mem_cmd == CMD_SELF_REFRESH |-> ##[0:1] (!o_mem_cke && o_idle_ack))
      else $error("self refresh entry without cke low and ack");
   a_self_refresh_src: assert property (
      o_mem_cmd == CMD_SELF_REFRESH |-> pwr_q[5:4] == TRIGGER_SELF_REFRESH
         || pwr_q[SELF_REFRESH_ON_IDLE_REQ_BIT] || pwr_q[SELF_REFRESH_ON_WARM_RST_BIT])
      else $error("self refresh entered with every source disabled");
   a_cke_pd_off: assert property (
      $fell(o_mem_cke) && !pwr_q[POWER_DOWN_ENABLE_BIT]
         |-> o_mem_cmd == CMD_SELF_REFRESH || $past(o_mem_cmd) == CMD_SELF_REFRESH)
      else $error("cke dropped with power-down disabled");
   a_ack_blocks_grant: assert property (
      o_idle_ack |-> !o_access_grant)
      else $error("grant while memory is in self refresh");
   a_clock_kept_on: assert property (
      !pwr_q[EXT_CLOCK_DISABLE_BIT] && pwr_q[5:4] != TRIGGER_CLOCK_STOP |-> o_mem_clk_en)
      else $error("memory clock stopped while clock disable is off");
endmodule : sdram_power_refresh_control_assertions

bind sdram_power_refresh_control sdram_power_refresh_control_assertions chk_inst (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .o_access_grant(o_access_grant), .o_idle_ack(o_idle_ack), .o_mem_cmd(o_mem_cmd),
   .o_mem_mode(o_mem_mode), .o_mem_cke(o_mem_cke), .o_mem_clk_en(o_mem_clk_en));

// file: tb/sdram_memory_model.sv
// Purpose: behavioural low-power sdram on the command side
// Assumes: commands are one cycle each, nop otherwise
// Notes:   no data path; counts refreshes and flags command misuse
`timescale 1ns/1ps
module sdram_memory_model
   import sdram_power_refresh_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic [2:0]  i_cmd,
   input  wire logic        i_cke,
   output logic      [15:0] o_refresh_cnt,
   output logic             o_proto_err
);
   // ======================================================
   // bank state
   logic precharged_q;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         precharged_q  <= 1'b0;
         o_refresh_cnt <= '0;
         o_proto_err   <= 1'b0;
      end
      else
      begin
         if (i_cmd == CMD_PRECHARGE_ALL)
            precharged_q <= 1'b1;
         else if (i_cmd == CMD_MODE_SET)
            precharged_q <= 1'b0;
         if (i_cmd == CMD_MODE_SET && !precharged_q)
            o_proto_err <= 1'b1;
         // a sleeping memory ignores commands, so any but self refresh is a fault
         if (!i_cke && i_cmd != CMD_NOP && i_cmd != CMD_SELF_REFRESH)
            o_proto_err <= 1'b1;
         if (i_cmd == CMD_AUTO_REFRESH)
            o_refresh_cnt <= o_refresh_cnt + 16'h0001;
      end
   end
endmodule : sdram_memory_model

// file: tb/sdram_power_refresh_control_test.sv
// Purpose: self-checking bench of sdram_power_refresh_control
// Assumes: read data stands only in the cycle after the read strobe
// Notes:   refresh interval shortened by register to keep the run brief
`timescale 1ns/1ps
module sdram_power_refresh_control_test import sdram_power_refresh_pkg::*;;
   // ======================================================
   // signals
   logic              i_clk;
   logic              i_rst_n;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata;
   logic              i_wr;
   logic              i_rd;
   logic [DATA_W-1:0] o_rdata;
   logic              i_access_req;
   logic              o_access_grant;
   logic              i_idle_req;
   logic              o_idle_ack;
   logic              i_warm_rst;
   cmd_t              o_mem_cmd;
   logic [MODE_W-1:0] o_mem_mode;
   logic              o_mem_cke;
   logic              o_mem_clk_en;
   logic [15:0]       refresh_cnt;
   logic              proto_err;
   int                failures = 0;
   int                n_tests = 0;

   sdram_power_refresh_control sdram_power_refresh_control_inst (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_access_req(i_access_req),
      .o_access_grant(o_access_grant), .i_idle_req(i_idle_req), .o_idle_ack(o_idle_ack),
      .i_warm_rst(i_warm_rst), .o_mem_cmd(o_mem_cmd), .o_mem_mode(o_mem_mode),
      .o_mem_cke(o_mem_cke), .o_mem_clk_en(o_mem_clk_en));
   sdram_memory_model sdram_memory_model_inst (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd(o_mem_cmd), .i_cke(o_mem_cke),
      .o_refresh_cnt(refresh_cnt), .o_proto_err(proto_err));

   // ======================================================
   // shared tasks
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1;
      d = o_rdata;
   endtask : reg_rd

   // sel: 0 ack, 1 grant, 2 cke low, 3 precharge; a hang ends the run
   task automatic wait_on(input int sel, input int n);
      logic hit;
      for (int k = 0; k < n; k++)
      begin
         @(posedge i_clk);
         #1;
         case (sel)
            0: hit = (o_idle_ack === 1'b1);
            1: hit = (o_access_grant === 1'b1);
            2: hit = (o_mem_cke === 1'b0);
            default: hit = (o_mem_cmd === CMD_PRECHARGE_ALL);
         endcase
         if (hit)
            return;
      end
      failures++;
      print_verdict();
   endtask : wait_on

   // request held until grant is seen at an edge
   task automatic wake();
      @(posedge i_clk);
      i_access_req <= 1'b1;
      wait_on(1, 80);
      @(posedge i_clk);
      i_access_req <= 1'b0;
   endtask : wake

   // ======================================================
   // scenarios
   task automatic t_reset();
      logic [31:0] d;
      reg_rd(MEMORY_POWER_CONTROL_OFS, d);
      cmp(d, POWER_CONTROL_RST);
      reg_rd(32'h6d000000, d);
      cmp(d, 32'h00000000);
      reg_rd(MEMORY_MODE_CONFIG_OFS, d);
      cmp(d, MODE_CONFIG_RST);
      repeat (200) @(posedge i_clk);
      #1;
      cmp({16'h0000, refresh_cnt}, 32'h00000000);
      cmp({31'h0, o_mem_cke}, 32'h00000001);
   endtask : t_reset

   task automatic t_restart();
      logic [31:0] d;
      reg_wr(REFRESH_INTERVAL_OFS, 32'h0000003f);
      reg_rd(MEMORY_MODE_CONFIG_OFS, d);
      reg_wr(MEMORY_MODE_CONFIG_OFS, d);
      wait_on(3, 20);
      repeat (4) @(posedge i_clk);
      #1;
      cmp({29'h0, o_mem_cmd}, {29'h0, CMD_MODE_SET});
      cmp({18'h0, o_mem_mode}, {18'h0, d[13:0]});
      // 64-cycle interval over 640 cycles, slack for the refresh wait
      repeat (640) @(posedge i_clk);
      #1;
      cmp({31'h0, refresh_cnt >= 16'h0008 && refresh_cnt <= 16'h000a}, 32'h00000001);
      cmp({31'h0, proto_err}, 32'h00000000);
   endtask : t_restart

   task automatic t_quiet();
      int bad;
      bad = 0;
      reg_wr(MEMORY_POWER_CONTROL_OFS, 32'h00000101);
      @(posedge i_clk);
      i_idle_req <= 1'b1;
      repeat (300)
      begin
         @(posedge i_clk);
         #1;
         if (o_mem_cke !== 1'b1 || o_idle_ack !== 1'b0)
            bad++;
      end
      @(posedge i_clk);
      i_idle_req <= 1'b0;
      cmp(32'(bad), 32'h00000000);
   endtask : t_quiet

   task automatic t_timeout();
      reg_wr(MEMORY_POWER_CONTROL_OFS, 32'h00000121);
      wait_on(0, 150);
      cmp({31'h0, o_mem_cke}, 32'h00000000);
      reg_wr(MEMORY_POWER_CONTROL_OFS, POWER_CONTROL_RST);
      wake();
   endtask : t_timeout

   task automatic t_idle_req();
      reg_wr(MEMORY_POWER_CONTROL_OFS, 32'h00000041);
      #1;
      cmp({31'h0, o_idle_ack}, 32'h00000000);
      @(posedge i_clk);
      i_idle_req <= 1'b1;
      wait_on(0, 40);
      @(posedge i_clk);
      i_idle_req <= 1'b0;
      wake();
   endtask : t_idle_req

   task automatic t_warm();
      reg_wr(MEMORY_POWER_CONTROL_OFS, 32'h00000081);
      @(posedge i_clk);
      i_warm_rst <= 1'b1;
      @(posedge i_clk);
      i_warm_rst <= 1'b0;
      wait_on(0, 40);
      wake();
   endtask : t_warm

   task automatic t_pdown();
      reg_wr(MEMORY_POWER_CONTROL_OFS, 32'h00000005);
      wait_on(2, 80);
      cmp({31'h0, o_idle_ack}, 32'h00000000);
      wake();
      #1;
      cmp({31'h0, proto_err}, 32'h00000000);
   endtask : t_pdown

   // ======================================================
   // main
   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   initial
   begin
      i_rst_n      = 1'b0;
      i_addr       = '0;
      i_wdata      = '0;
      i_wr         = 1'b0;
      i_rd         = 1'b0;
      i_access_req = 1'b0;
      i_idle_req   = 1'b0;
      i_warm_rst   = 1'b0;
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_reset();
      t_restart();
      t_quiet();
      t_timeout();
      t_idle_req();
      t_warm();
      t_pdown();
      print_verdict();
   end
endmodule : sdram_power_refresh_control_test
